// >>> bench/smc_bus_dev.sv
// far-side bus device driving the port1 lines
`timescale 1ns/1ns
`default_nettype none
module smc_bus_dev (
  // sample clock
  input wire logic clk,
  // lines, high when released
  output var logic sda,
  output var logic scl
);
  initial
  begin
    sda = 1'b1;
    scl = 1'b1;
  end
  task automatic start(input int gap);
    @(posedge clk);
    sda <= 1'b0;
    repeat (gap) @(posedge clk);
    scl <= 1'b0;
  endtask
  task automatic stop();
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // data released first so no stop; clock at 160 ns, ends high
  task automatic bits(input int n);
    @(posedge clk);
    sda <= 1'b1;
    repeat (2 * n + 1)
    begin
      repeat (4) @(posedge clk);
      scl <= ~scl;
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/smc_props.sv
// concurrent checks on the smbus configuration block
`timescale 1ns/1ns
`default_nettype none
module smc_props
  import smc_pkg::*;
(
  // clock, reset, register writes
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  // engine, timer and status
  input wire logic master_event,
  input wire logic [3:0] timer_ovf,
  input wire logic [1:0] start_detect,
  input wire logic stop_detect,
  input wire logic transfer_active_flag,
  input wire logic irq,
  input wire logic timer_reload_hi,
  input wire logic timer_reload_lo,
  input wire logic bitrate_tick
);
  // shadow of port1_config; page filter keeps stray writes out
  logic [7:0] cf_r;
  always_ff @(posedge clk)
    if (!nrst)
      cf_r <= 8'h00;
    else if (sfr_wr && sfr_addr == ADDR_PORT1_CONFIG && sfr_page == PAGE_PORT1_CONFIG)
      cf_r <= sfr_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence off2;
    !cf_r[CF_ENABLE] ##1 !cf_r[CF_ENABLE];
  endsequence
  a_start_one_cycle: assert property (start_detect[1] |=> !start_detect[1])
    else $error("start pulse too long");
  a_busy_after_start: assert property (start_detect[1] |=> transfer_active_flag)
    else $error("busy not set");
  a_stop_clears_busy: assert property (stop_detect |=> !transfer_active_flag)
    else $error("busy kept after stop");
  a_master_irq: assert property (master_event && cf_r[CF_ENABLE] |=> irq)
    else $error("master irq lost");
  a_no_irq_off: assert property (off2 |-> !irq)
    else $error("irq while off");
  a_no_start_off: assert property (off2 |-> !start_detect[1])
    else $error("start while off");
  a_split_lo_held: assert property (timer_reload_lo |-> timer_reload_hi)
    else $error("low reload alone");
  a_tick_follows_ovf: assert property (timer_ovf[cf_r[1:0]] |=> bitrate_tick)
    else $error("tick missing");
endmodule
bind smc_top smc_props u_props (.*);
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the smbus configuration block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import smc_pkg::*;
  logic clk, nrst, sfr_wr, sfr_rd, sw, timeout_split_mode, sda, scl, stop_detect, irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [3:0] sfr_page, pin_i, pin_o, pin_oe, timer_ovf;
  logic [1:0] start_detect;
  logic [5:0] pls;
  logic [4:0] obs;
  logic port0_enable, slave_event, master_event, transfer_begin, transfer_active_flag;
  logic timer_reload_hi, timer_reload_lo, bitrate_tick;
  smc_line_t p0_drive_low, p1_drive_low;
  int err_count, total_checks, i;
  logic [3:0] win [4] = '{WIN_00, WIN_01, WIN_10, WIN_11};
  assign {master_event, slave_event, timer_ovf} = pls;
  assign obs = {timer_reload_lo, timer_reload_hi, bitrate_tick, irq, start_detect[1]};
  // open drain: pulled up unless the block pulls low, or for the port1 pins the bus device
  assign pin_i = {(sw ? {sda, scl} : {scl, sda}) & ~pin_oe[3:2], ~pin_oe[1:0]};
  // port1 drive requests come from the bench to exercise the hold and setup timing
  assign {port0_enable, transfer_begin, p0_drive_low} = 4'h0;
  smc_top dut (.*);
  smc_bus_dev dev (.clk(clk), .sda(sda), .scl(scl));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d, input logic [3:0] pg = 4'hf);
    @(posedge clk);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_page <= pg;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    @(posedge clk);
    if (!w)
      chk(sfr_rdata, d);
  endtask
  // optional one-cycle pulse, then watch one output for 14 cycles
  task automatic see(input int s, input logic exp, input logic [5:0] v = 6'h00);
    logic hit;
    hit = 1'b0;
    @(posedge clk);
    pls <= v;
    repeat (14)
    begin
      @(posedge clk);
      pls <= 6'h00;
      hit |= obs[s];
    end
    chk({7'h0, hit}, {7'h0, exp});
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {nrst, sfr_wr, sfr_rd, sw, timeout_split_mode, sfr_addr, sfr_wdata, sfr_page, pls} = 31'h0;
    err_count = 0;
    total_checks = 0;
    p1_drive_low = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    acc(0, ADDR_TIMING_PIN_CTRL, TIMING_RESET);
    acc(1, ADDR_TIMING_PIN_CTRL, 8'h30);
    acc(0, ADDR_TIMING_PIN_CTRL, 8'h30);
    acc(0, 8'hc2, 8'h00);
    acc(1, ADDR_PORT1_CONFIG, 8'hff, 4'h0);
    acc(0, ADDR_PORT1_CONFIG, CONFIG_RESET);
    acc(1, ADDR_PORT1_CONFIG, 8'hff);
    acc(0, ADDR_PORT1_CONFIG, 8'hdf);
    for (i = 0; i < 4; i++)
    begin
      acc(1, ADDR_TIMING_PIN_CTRL, {4'h0, i[1:0], 2'h0});
      acc(1, ADDR_PORT1_CONFIG, {6'h20, i[1:0]});
      see(2, 1'b0, 6'h1 << ((i + 1) % 4));
      see(2, 1'b1, 6'h1 << i);
      dev.start(win[i] > 1 ? win[i] - 2 : 0);
      see(0, 1'b0);
      dev.stop();
      dev.start(win[i] + 1);
      see(0, 1'b1);
      acc(0, ADDR_PORT1_CONFIG, {6'h28, i[1:0]});
      dev.stop();
      acc(0, ADDR_PORT1_CONFIG, {6'h20, i[1:0]});
    end
    acc(1, ADDR_PORT1_CONFIG, 8'h40);
    dev.start(10);
    see(0, 1'b0);
    see(1, 1'b0, 6'h20);
    dev.stop();
    acc(1, ADDR_PORT1_CONFIG, 8'hc0);
    see(1, 1'b0, 6'h10);
    see(1, 1'b1, 6'h20);
    acc(1, ADDR_TIMING_PIN_CTRL, 8'h80);
    sw <= 1'b1;
    timeout_split_mode <= 1'b1;
    acc(1, ADDR_PORT1_CONFIG, 8'h9c);
    see(3, 1'b1);
    see(4, 1'b0);
    dev.start(10);
    see(0, 1'b1);
    chk({7'h0, timer_reload_hi}, 8'h00);
    dev.bits(2);
    repeat (4) @(posedge clk);
    repeat (10) see(2, 1'b1, 6'h01);
    acc(0, ADDR_PORT1_CONFIG, 8'hbc);
    see(2, 1'b1, 6'h01);
    acc(0, ADDR_PORT1_CONFIG, 8'h9c);
    // extended timing: sda pull waits for the hold after scl falls
    dev.start(10);
    repeat (4) @(posedge clk);
    p1_drive_low <= '{data: 1'b1, clock: 1'b0};
    i = 0;
    while (!pin_oe[3] && i < 40)
    begin
      @(posedge clk);
      i++;
    end
    chk({7'h0, i >= HOLD_EXTEND && i < 40}, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h0, pin_oe[2]}, 8'h01);
    p1_drive_low <= '0;
    repeat (20) @(posedge clk);
    chk({pin_o, pin_oe}, 8'h00);
    dev.stop();
    acc(0, ADDR_PORT1_CONFIG, 8'h9c);
    finish_test();
  end
endmodule
`default_nettype wire

// >>> design/smc_pkg.sv
// constants and types for the smbus configuration and start-detect block
package smc_pkg;
  localparam logic [7:0] ADDR_PORT1_CONFIG = 8'hc1;
  localparam logic [7:0] ADDR_TIMING_PIN_CTRL = 8'hc7;
  localparam logic [3:0] PAGE_PORT1_CONFIG = 4'hf;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'h00;
  // port1_config fields
  localparam int CF_ENABLE = 7;
  localparam int CF_INHIBIT = 6;
  localparam int CF_BUSY = 5;
  localparam int CF_EXTEND = 4;
  localparam int CF_TOE = 3;
  localparam int CF_FTE = 2;
  localparam int CF_CS_LO = 0;
  // timing_and_pin_control fields
  localparam int TC_SWAP1 = 7;
  localparam int TC_SWAP0 = 6;
  localparam int TC_WIN1_LO = 2;
  localparam int TC_WIN0_LO = 0;
  // clock-source select codes
  localparam logic [1:0] CS_T0 = 2'h0;
  localparam logic [1:0] CS_T5 = 2'h1;
  localparam logic [1:0] CS_T2H = 2'h2;
  localparam logic [1:0] CS_T2L = 2'h3;
  // sda timing in system clocks
  localparam logic [3:0] HOLD_NORMAL = 4'h3;
  localparam logic [3:0] HOLD_EXTEND = 4'hc;
  localparam logic [3:0] SETUP_EXTEND = 4'hb;
  // bus free after more than this many source periods with both lines high
  localparam logic [3:0] FREE_PERIODS = 4'ha;
  // least sda-fall to scl-fall spacing per window code, in system clocks
  localparam logic [3:0] WIN_00 = 4'h1;
  localparam logic [3:0] WIN_01 = 4'h3;
  localparam logic [3:0] WIN_10 = 4'h5;
  localparam logic [3:0] WIN_11 = 4'h9;

  typedef struct packed {
    logic data;
    logic clock;
  } smc_line_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] cfg;
    logic [7:0] tc;
    logic busy;
    logic [3:0] sync1;
    logic [3:0] sync2;
    smc_line_t [1:0] prev;
    logic [1:0][3:0] fall_cnt;
    logic [1:0] start;
    logic stop;
    logic [3:0] free_cnt;
    logic [3:0] hold_cnt;
    logic [3:0] setup_cnt;
    logic p1_sda_low;
    logic [3:0] pin_oe;
    logic [3:0] pin_o;
    logic reload_hi;
    logic reload_lo;
    logic rate_tick;
    logic irq;
  } smc_state_t;
endpackage

// >>> design/smc_top.sv
// smbus port configuration, timing control and start detection
// Operation
// - enabled port watches its data and clock
// - inhibit masks slave interrupts, master ones pass
// - busy set on transfer, cleared stop/free
// - extension bit picks normal or extended timing
// - extended: setup 11, hold 12; else hold 3
// - timeout: reload while clock high, count low
// - split mode: only high byte held reloading
// - free when both lines high over 10 periods
// - source select: t0, t5, t2 high, t2 low
// - port1 swap reverses data and clock pins
// - port0 swap reverses data and clock pins
// - start needs sda fall before scl by window
// - port1 window: 0-1, 2-3, 4-5, 8-9 clocks
// - port0 window uses the same encoding
`timescale 1ns/1ns
`default_nettype none
module smc_top
  import smc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // pins: bit0 port0 low, bit1 port0 high, bit2 port1 low, bit3 port1 high
  input wire logic [3:0] pin_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe,
  // transfer engine side
  input wire logic port0_enable,
  input wire smc_line_t p0_drive_low,
  input wire smc_line_t p1_drive_low,
  input wire logic slave_event,
  input wire logic master_event,
  input wire logic transfer_begin,
  output logic [1:0] start_detect,
  output logic stop_detect,
  output logic transfer_active_flag,
  output logic irq,
  // timers
  input wire logic [3:0] timer_ovf,
  input wire logic timeout_split_mode,
  output logic timer_reload_hi,
  output logic timer_reload_lo,
  output logic bitrate_tick
);

  smc_state_t s_r;
  smc_state_t s_nxt;

  function automatic logic [3:0] win_min(input logic [1:0] code);
    unique case (code)
      2'h0: win_min = WIN_00;
      2'h1: win_min = WIN_01;
      2'h2: win_min = WIN_10;
      2'h3: win_min = WIN_11;
    endcase
  endfunction

  // swap=0: data on the low pin, clock on the high pin
  function automatic smc_line_t route_in(input logic [1:0] pins, input logic swap);
    route_in.data = swap ? pins[1] : pins[0];
    route_in.clock = swap ? pins[0] : pins[1];
  endfunction

  function automatic logic [1:0] route_out(input smc_line_t ln, input logic swap);
    route_out = swap ? {ln.data, ln.clock} : {ln.clock, ln.data};
  endfunction

  smc_line_t cur [2];
  logic [1:0] en;
  logic [1:0] swap;
  logic [1:0][1:0] win;
  logic ext;
  logic src_tick;
  logic [3:0] hold_len;
  logic p1_scl_low;

  always_comb
  begin
    s_nxt = s_r;
    swap = {s_r.tc[TC_SWAP1], s_r.tc[TC_SWAP0]};
    win[1] = s_r.tc[TC_WIN1_LO +: 2];
    win[0] = s_r.tc[TC_WIN0_LO +: 2];
    en = {s_r.cfg[CF_ENABLE], port0_enable};
    ext = s_r.cfg[CF_EXTEND];
    cur[0] = route_in(s_r.sync2[1:0], swap[0]);
    cur[1] = route_in(s_r.sync2[3:2], swap[1]);

    // register port; busy is read-only
    if (sfr_wr && sfr_addr == ADDR_PORT1_CONFIG && sfr_page == PAGE_PORT1_CONFIG)
    begin
      s_nxt.cfg = sfr_wdata;
    end
    // reserved bits stored as written
    if (sfr_wr && sfr_addr == ADDR_TIMING_PIN_CTRL)
    begin
      s_nxt.tc = sfr_wdata;
    end
    if (sfr_rd && sfr_addr == ADDR_PORT1_CONFIG && sfr_page == PAGE_PORT1_CONFIG)
    begin
      s_nxt.rdata = s_r.cfg;
      s_nxt.rdata[CF_BUSY] = s_r.busy;
    end
    else if (sfr_rd && sfr_addr == ADDR_TIMING_PIN_CTRL)
    begin
      s_nxt.rdata = s_r.tc;
    end
    else if (sfr_rd)
    begin
      s_nxt.rdata = 8'h00;
    end

    // pin synchroniser
    s_nxt.sync1 = pin_i;
    s_nxt.sync2 = s_r.sync1;

    // start watch for both ports, stop watch for port1 only
    s_nxt.start = 2'h0;
    s_nxt.stop = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      s_nxt.prev[p] = cur[p];
      if (!en[p])
      begin
        s_nxt.fall_cnt[p] = 4'h0;
      end
      else if (cur[p].clock && s_r.prev[p].data && !cur[p].data)
      begin
        s_nxt.fall_cnt[p] = 4'h1;
      end
      else if (cur[p].clock && !cur[p].data && s_r.fall_cnt[p] != 4'h0
               && s_r.fall_cnt[p] != 4'hf)
      begin
        s_nxt.fall_cnt[p] = s_r.fall_cnt[p] + 4'h1;
      end
      else if (!cur[p].clock || cur[p].data)
      begin
        s_nxt.fall_cnt[p] = 4'h0;
      end
      // scl falls while sda low long enough
      if (en[p] && s_r.prev[p].clock && !cur[p].clock && !cur[p].data
          && s_r.fall_cnt[p] >= win_min(win[p]))
      begin
        s_nxt.start[p] = 1'b1;
      end
    end
    if (en[1] && cur[1].clock && !s_r.prev[1].data && cur[1].data)
    begin
      s_nxt.stop = 1'b1;
    end

    // clock source and free timeout
    unique case (s_r.cfg[CF_CS_LO +: 2])
      CS_T0: src_tick = timer_ovf[0];
      CS_T5: src_tick = timer_ovf[1];
      CS_T2H: src_tick = timer_ovf[2];
      CS_T2L: src_tick = timer_ovf[3];
    endcase
    s_nxt.rate_tick = en[1] & src_tick;
    if (!(cur[1].clock && cur[1].data) || !en[1])
    begin
      s_nxt.free_cnt = 4'h0;
    end
    else if (src_tick && s_r.free_cnt <= FREE_PERIODS)
    begin
      s_nxt.free_cnt = s_r.free_cnt + 4'h1;
    end

    // busy: set by start or engine, cleared by stop or free timeout
    if (!en[1])
    begin
      s_nxt.busy = 1'b0;
    end
    else if (s_nxt.start[1] || transfer_begin)
    begin
      s_nxt.busy = 1'b1;
    end
    else if (s_r.stop || (s_r.cfg[CF_FTE] && s_r.free_cnt > FREE_PERIODS))
    begin
      s_nxt.busy = 1'b0;
    end

    // scl timeout timer control
    s_nxt.reload_hi = en[1] && s_r.cfg[CF_TOE] && cur[1].clock;
    s_nxt.reload_lo = s_nxt.reload_hi && !timeout_split_mode;

    // interrupt: slave events gated by inhibit
    s_nxt.irq = en[1] && (master_event || (slave_event && !s_r.cfg[CF_INHIBIT]));

    // sda hold after scl falls, sda setup before scl release
    hold_len = ext ? HOLD_EXTEND : HOLD_NORMAL;
    if (s_r.prev[1].clock && !cur[1].clock)
    begin
      s_nxt.hold_cnt = hold_len;
    end
    else if (s_r.hold_cnt != 4'h0)
    begin
      s_nxt.hold_cnt = s_r.hold_cnt - 4'h1;
    end
    if (s_r.hold_cnt == 4'h0 && s_r.p1_sda_low != p1_drive_low.data)
    begin
      s_nxt.p1_sda_low = p1_drive_low.data;
      s_nxt.setup_cnt = ext ? SETUP_EXTEND : 4'h0;
    end
    else if (s_r.setup_cnt != 4'h0)
    begin
      s_nxt.setup_cnt = s_r.setup_cnt - 4'h1;
    end
    // hold scl low until the setup time has passed
    p1_scl_low = p1_drive_low.clock || (s_r.pin_oe[3:2] != 2'h0 && s_r.setup_cnt != 4'h0
                 && route_out('{data: s_r.p1_sda_low, clock: 1'b1}, swap[1]) != 2'h0);
    s_nxt.pin_oe[1:0] = en[0] ? route_out(p0_drive_low, swap[0]) : 2'h0;
    s_nxt.pin_oe[3:2] = en[1]
                        ? route_out('{data: s_r.p1_sda_low, clock: p1_scl_low}, swap[1])
                        : 2'h0;
    s_nxt.pin_o = 4'h0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.cfg <= CONFIG_RESET;
      s_r.tc <= TIMING_RESET;
      s_r.sync1 <= 4'hf;
      s_r.sync2 <= 4'hf;
      s_r.prev <= '1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata = s_r.rdata;
  assign pin_o = s_r.pin_o;
  assign pin_oe = s_r.pin_oe;
  assign start_detect = s_r.start;
  assign stop_detect = s_r.stop;
  assign transfer_active_flag = s_r.busy;
  assign irq = s_r.irq;
  assign timer_reload_hi = s_r.reload_hi;
  assign timer_reload_lo = s_r.reload_lo;
  assign bitrate_tick = s_r.rate_tick;

endmodule
`default_nettype wire
